// file: hdl/wku_unit.sv
/*
 * wku_unit: wakeup and interrupt unit with 30 pad sources, 2 on-chip
 * sources and 2 nmi inputs, edge detection, write-one-to-clear flags,
 * grouped interrupt vectors and one combined wakeup request.
 * assumes: pad inputs asynchronous and synchronised here; glitch filter
 * and pullup are analog, driven by enables; registers on plain port.
 */
// Function
// - a source flag clears only by writing one to its bit
// - set pad flag with irq enable raises its group's interrupt vector; on-chip flags raise none
// - set flag with wakeup enable raises the system wakeup request
// - a matching enabled edge on a source sets its flag
// - rise enable makes low-to-high transitions events
// - fall enable makes high-to-low transitions events; both may be set
// - pad filter enables drive glitch filters; timer source has none
// - pullup enable requests a pad pullup to logic one
// - requested pullup takes effect at next standby entry, overriding port pulls
// - pullup ownership released only by pullup register access or reset
// - two nmi inputs, three routing types, second event captured
// - nmi flag set on configured edge; its register is write-one-to-clear
// - nmi overrun set on new event while nmi flag still set
// - nmi request stays while overrun set; overrun cleared by writing one
// - both nmi edge enables zero detect nothing
// - nmi edge enables are zero after reset
// - enabled nmi function blocks pin multiplexer override of the pad
// - pad sources grouped onto four vectors in sequential blocks; on-chip sources on none
// - both source edge enables zero give neither wakeup nor interrupt
// - on-chip and pad wakeups merge into one wakeup output
// - on-chip flags share the pad flag register
// - destination code 00 nmi, 01 critical, 10 machine check, 11 none
// - writing one to nmi lock freezes its configuration until reset
// - nmi wakeup enable makes set flag or overrun request wakeup
// - thirty pad sources with own enable, edge and pullup control
`timescale 1ns/1ps
`default_nettype none
module wku_unit #(
    parameter int GROUP = 8
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst,
    // register port
    input  wire logic [wku_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [31:0]                reg_rdata,
    // source inputs
    input  wire logic [wku_pkg::NUM_EXT-1:0] pad_in,
    input  wire logic                        timer_wake_in,
    input  wire logic                        onchip_wake_in,
    input  wire logic [wku_pkg::NUM_NMI-1:0] nmi_pad_in,
    input  wire logic                        standby_entry,
    // requests
    output logic [wku_pkg::NUM_VEC-1:0]     irq_vec,
    output logic                            wakeup_req,
    output wku_pkg::wku_nmi_req_t           nmi_req,
    // pad control
    output logic [wku_pkg::NUM_EXT-1:0]     filter_en,
    output logic [wku_pkg::NUM_EXT-1:0]     pullup_on,
    output logic [wku_pkg::NUM_NMI-1:0]     nmi_filter_en,
    output logic [wku_pkg::NUM_NMI-1:0]     nmi_mux_lock
);
    localparam int NIN = wku_pkg::NUM_SRC + wku_pkg::NUM_NMI;

    typedef struct packed {
        logic [NIN-1:0]                   sync1;
        logic [NIN-1:0]                   sync2;
        logic [NIN-1:0]                   prev;
        logic [31:0]                      flags;
        logic [31:0]                      irq_en;
        logic [31:0]                      wake_en;
        logic [31:0]                      rise_en;
        logic [31:0]                      fall_en;
        logic [31:0]                      filt_en;
        logic [31:0]                      pull_en;
        logic [wku_pkg::NUM_EXT-1:0]      pull_act;
        logic [15:0]                      nmi_cfg;
        logic [15:0]                      nmi_flg;
        wku_pkg::wku_mode_t               mode;
        logic [31:0]                      rdata;
        logic [wku_pkg::NUM_VEC-1:0]      vec;
        logic                             wake;
        wku_pkg::wku_nmi_req_t            nreq;
        logic [wku_pkg::NUM_NMI-1:0]      mux_lk;
    } wku_state_t;

    wku_state_t st_ff;
    wku_state_t nxt_st;

    // edge detection against enables, shared by sources and nmi inputs
    function automatic logic edge_hit(input logic cur, input logic old,
                                      input logic re, input logic fe);
        edge_hit = (re & cur & ~old) | (fe & ~cur & old);
    endfunction : edge_hit

    logic [31:0] src_evt;
    logic [wku_pkg::NUM_NMI-1:0] nmi_evt;
    logic [31:0] wr1c;
    logic        hit_flags;
    logic        hit_ncfg;
    logic        hit_nflg;
    logic        hit_pull;

    // address decode and event detection
    always_comb begin
        hit_flags = reg_addr == wku_pkg::OFS_FLAGS;
        hit_ncfg  = reg_addr == wku_pkg::OFS_NMI_CFG;
        hit_nflg  = reg_addr == wku_pkg::OFS_NMI_FLAGS;
        hit_pull  = reg_addr == wku_pkg::OFS_PULL_EN;
        wr1c      = (reg_wr && hit_flags) ? reg_wdata : wku_pkg::RST_WORD;
        for (int i = 0; i < wku_pkg::NUM_SRC; i++) begin
            // both enables zero yield no event
            src_evt[i] = edge_hit(st_ff.sync2[i], st_ff.prev[i],
                                  st_ff.rise_en[i], st_ff.fall_en[i]);
        end
        for (int n = 0; n < wku_pkg::NUM_NMI; n++) begin
            nmi_evt[n] = edge_hit(st_ff.sync2[wku_pkg::NUM_SRC+n],
                st_ff.prev[wku_pkg::NUM_SRC+n],
                st_ff.nmi_cfg[n*wku_pkg::NMI_CFG_W+wku_pkg::NCF_RISE],
                st_ff.nmi_cfg[n*wku_pkg::NMI_CFG_W+wku_pkg::NCF_FALL]);
        end
    end

    // next-state logic
    always_comb begin
        nxt_st = st_ff;
        // two-stage synchroniser, then edge history
        nxt_st.sync1 = {nmi_pad_in, onchip_wake_in, timer_wake_in, pad_in};
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.prev  = st_ff.sync2;
        // set wins over write-one clear
        nxt_st.flags = (st_ff.flags & ~wr1c) | src_evt;
        if (reg_wr) begin
            case (reg_addr)
                wku_pkg::OFS_IRQ_EN:  nxt_st.irq_en  = reg_wdata;
                wku_pkg::OFS_WAKE_EN: nxt_st.wake_en = reg_wdata;
                wku_pkg::OFS_RISE_EN: nxt_st.rise_en = reg_wdata;
                wku_pkg::OFS_FALL_EN: nxt_st.fall_en = reg_wdata;
                wku_pkg::OFS_FILT_EN: nxt_st.filt_en = reg_wdata;
                wku_pkg::OFS_PULL_EN: nxt_st.pull_en = reg_wdata;
                default: ;
            endcase
        end
        for (int n = 0; n < wku_pkg::NUM_NMI; n++) begin
            // locked byte ignores writes; lock bit only sets
            if (reg_wr && hit_ncfg
                && !st_ff.nmi_cfg[n*wku_pkg::NMI_CFG_W+wku_pkg::NCF_LOCK]) begin
                nxt_st.nmi_cfg[n*wku_pkg::NMI_CFG_W +: wku_pkg::NMI_CFG_W] =
                    reg_wdata[n*wku_pkg::NMI_CFG_W +: wku_pkg::NMI_CFG_W];
            end
            // a new event ORs the current flag into overrun
            if (reg_wr && hit_nflg) begin
                nxt_st.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_EVENT] =
                    st_ff.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_EVENT]
                    & ~reg_wdata[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_EVENT];
                nxt_st.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_OVR] =
                    st_ff.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_OVR]
                    & ~reg_wdata[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_OVR];
            end
            if (nmi_evt[n]) begin
                nxt_st.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_OVR] =
                    st_ff.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_EVENT]
                    | nxt_st.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_OVR];
                nxt_st.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_EVENT] = 1'b1;
            end
            // pad lock follows the new edge enables, registered with them
            nxt_st.mux_lk[n] = nxt_st.nmi_cfg[n*wku_pkg::NMI_CFG_W+wku_pkg::NCF_RISE]
                             | nxt_st.nmi_cfg[n*wku_pkg::NMI_CFG_W+wku_pkg::NCF_FALL];
        end
        // mode tracking and pullup ownership
        case (st_ff.mode)
            wku_pkg::WKU_RUN: begin
                if (standby_entry) begin
                    nxt_st.mode     = wku_pkg::WKU_STBY;
                    nxt_st.pull_act = st_ff.pull_en[wku_pkg::NUM_EXT-1:0];
                end
            end
            wku_pkg::WKU_STBY: begin
                if (!standby_entry) begin
                    nxt_st.mode = wku_pkg::WKU_RUN;
                end
            end
            default: nxt_st.mode = wku_pkg::WKU_RUN;
        endcase
        if ((reg_wr || reg_rd) && hit_pull) begin
            nxt_st.pull_act = '0;
        end
        // grouped vectors
        nxt_st.vec = '0;
        for (int i = 0; i < wku_pkg::NUM_EXT; i++) begin
            if (i / GROUP < wku_pkg::NUM_VEC) begin
                nxt_st.vec[i/GROUP] = nxt_st.vec[i/GROUP]
                    | (st_ff.flags[i] & st_ff.irq_en[i]);
            end
        end
        // combined wakeup
        nxt_st.wake = |(st_ff.flags & st_ff.wake_en);
        nxt_st.nreq = '0;
        for (int n = 0; n < wku_pkg::NUM_NMI; n++) begin
            if (st_ff.nmi_cfg[n*wku_pkg::NMI_CFG_W+wku_pkg::NCF_WAKE]
                && (st_ff.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_EVENT]
                 || st_ff.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_OVR])) begin
                nxt_st.wake = 1'b1;
            end
            // destination routing; code 11 raises nothing
            if (st_ff.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_EVENT]
                || st_ff.nmi_flg[n*wku_pkg::NMI_CFG_W+wku_pkg::NFL_OVR]) begin
                case (st_ff.nmi_cfg[n*wku_pkg::NMI_CFG_W+wku_pkg::NCF_DST_LO +: 2])
                    wku_pkg::DST_NMI:  nxt_st.nreq.nmi[n]  = 1'b1;
                    wku_pkg::DST_CRIT: nxt_st.nreq.crit[n] = 1'b1;
                    wku_pkg::DST_MCHK: nxt_st.nreq.mchk[n] = 1'b1;
                    default: ;
                endcase
            end
        end
        // read data, unmapped reads zero
        nxt_st.rdata = wku_pkg::RST_WORD;
        if (reg_rd) begin
            case (reg_addr)
                wku_pkg::OFS_NMI_FLAGS: nxt_st.rdata = {16'h0000, st_ff.nmi_flg};
                wku_pkg::OFS_NMI_CFG:   nxt_st.rdata = {16'h0000, st_ff.nmi_cfg};
                wku_pkg::OFS_FLAGS:     nxt_st.rdata = st_ff.flags;
                wku_pkg::OFS_IRQ_EN:    nxt_st.rdata = st_ff.irq_en;
                wku_pkg::OFS_WAKE_EN:   nxt_st.rdata = st_ff.wake_en;
                wku_pkg::OFS_RISE_EN:   nxt_st.rdata = st_ff.rise_en;
                wku_pkg::OFS_FALL_EN:   nxt_st.rdata = st_ff.fall_en;
                wku_pkg::OFS_FILT_EN:   nxt_st.rdata = st_ff.filt_en;
                wku_pkg::OFS_PULL_EN:   nxt_st.rdata = st_ff.pull_en;
                default:                nxt_st.rdata = wku_pkg::RST_WORD;
            endcase
        end
    end

    // state register; nmi edge enables zero after reset
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.mode <= wku_pkg::WKU_RUN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from state flops
    assign reg_rdata = st_ff.rdata;
    assign irq_vec   = st_ff.vec;
    assign wakeup_req = st_ff.wake;
    assign nmi_req   = st_ff.nreq;
    // timer source has no filter
    assign filter_en = st_ff.filt_en[wku_pkg::NUM_EXT-1:0];
    assign pullup_on = st_ff.pull_act;
    always_comb begin
        for (int n = 0; n < wku_pkg::NUM_NMI; n++) begin
            nmi_filter_en[n] = st_ff.nmi_cfg[n*wku_pkg::NMI_CFG_W+wku_pkg::NCF_FILT];
        end
    end
    // enabled nmi holds the pad against mux changes
    assign nmi_mux_lock = st_ff.mux_lk;

    // a flag write-one clear with no event empties the bit
    a_flag_clear: assert property (@(posedge clk) disable iff (rst)
        reg_wr && hit_flags && reg_wdata[0] && !src_evt[0] |=> !st_ff.flags[0])
        else $error("flag not cleared by write one");
    a_flag_hold: assert property (@(posedge clk) disable iff (rst)
        reg_wr && hit_flags && !reg_wdata[9] && st_ff.flags[9] |=> st_ff.flags[9])
        else $error("flag lost on zero write");
    a_flag_set: assert property (@(posedge clk) disable iff (rst)
        src_evt[0] |=> st_ff.flags[0])
        else $error("event did not set flag");
    a_set_wins: assert property (@(posedge clk) disable iff (rst)
        src_evt[5] && wr1c[5] |=> st_ff.flags[5])
        else $error("clear beat a same-cycle event");
    a_onchip_flag: assert property (@(posedge clk) disable iff (rst)
        src_evt[wku_pkg::ONCHIP_BIT] |=> st_ff.flags[wku_pkg::ONCHIP_BIT])
        else $error("on-chip flag missing");

    // edge selection
    a_rise_event: assert property (@(posedge clk) disable iff (rst)
        st_ff.rise_en[9] && st_ff.sync2[9] && !st_ff.prev[9] |=> st_ff.flags[9])
        else $error("rising edge missed");
    a_fall_event: assert property (@(posedge clk) disable iff (rst)
        st_ff.fall_en[17] && !st_ff.sync2[17] && st_ff.prev[17] |=> st_ff.flags[17])
        else $error("falling edge missed");
    a_edge_quiet: assert property (@(posedge clk) disable iff (rst)
        !st_ff.rise_en[25] && !st_ff.fall_en[25] && !st_ff.flags[25] |=> !st_ff.flags[25])
        else $error("disabled source flagged");

    // request outputs
    a_vec_zero: assert property (@(posedge clk) disable iff (rst)
        (st_ff.flags[7:0] & st_ff.irq_en[7:0]) == 8'h00 |=> !irq_vec[0])
        else $error("vector raised with no enabled flag");
    a_vec_raise: assert property (@(posedge clk) disable iff (rst)
        st_ff.flags[0] && st_ff.irq_en[0] |=> irq_vec[0])
        else $error("vector missing enabled flag");
    a_vec_group: assert property (@(posedge clk) disable iff (rst)
        st_ff.flags[17] && st_ff.irq_en[17] |=> irq_vec[2])
        else $error("source on wrong vector");
    a_wake_merge: assert property (@(posedge clk) disable iff (rst)
        st_ff.flags[wku_pkg::TIMER_BIT] && st_ff.wake_en[wku_pkg::TIMER_BIT]
        |=> wakeup_req)
        else $error("on-chip wakeup not merged");
    a_wake_gate: assert property (@(posedge clk) disable iff (rst)
        st_ff.wake_en == 32'h0 && !st_ff.nmi_cfg[wku_pkg::NCF_WAKE]
        && !st_ff.nmi_cfg[wku_pkg::NMI_CFG_W+wku_pkg::NCF_WAKE] |=> !wakeup_req)
        else $error("wakeup without enable");

    // nmi flags, routing and lock
    a_nmi_set: assert property (@(posedge clk) disable iff (rst)
        nmi_evt[0] |=> st_ff.nmi_flg[wku_pkg::NFL_EVENT])
        else $error("nmi flag not set");
    a_nmi_ovr: assert property (@(posedge clk) disable iff (rst)
        nmi_evt[0] && st_ff.nmi_flg[wku_pkg::NFL_EVENT] |=> st_ff.nmi_flg[wku_pkg::NFL_OVR])
        else $error("nmi overrun not captured");
    a_nmi_dst: assert property (@(posedge clk) disable iff (rst)
        st_ff.nmi_flg[wku_pkg::NFL_OVR] && st_ff.nmi_cfg[wku_pkg::NCF_DST_LO +: 2] == 2'h1
        |=> nmi_req.crit[0] && !nmi_req.nmi[0])
        else $error("nmi routing wrong");
    a_nmi_pend: assert property (@(posedge clk) disable iff (rst)
        st_ff.nmi_flg[wku_pkg::NFL_OVR] && st_ff.nmi_cfg[wku_pkg::NCF_DST_LO +: 2] != 2'h3
        |=> nmi_req.nmi[0] || nmi_req.crit[0] || nmi_req.mchk[0])
        else $error("overrun request dropped");
    a_rsv_code: assert property (@(posedge clk) disable iff (rst)
        st_ff.nmi_cfg[wku_pkg::NCF_DST_LO +: 2] == 2'h3
        |=> !nmi_req.nmi[0] && !nmi_req.crit[0] && !nmi_req.mchk[0])
        else $error("reserved code raised request");
    a_nmi_wake: assert property (@(posedge clk) disable iff (rst)
        st_ff.nmi_cfg[wku_pkg::NCF_WAKE] && st_ff.nmi_flg[wku_pkg::NFL_EVENT] |=> wakeup_req)
        else $error("nmi wakeup missing");
    a_nmi_lock: assert property (@(posedge clk) disable iff (rst)
        st_ff.nmi_cfg[wku_pkg::NCF_LOCK] |=> $stable(st_ff.nmi_cfg[7:0]))
        else $error("locked nmi config changed");
    a_mux_lock: assert property (@(posedge clk) disable iff (rst)
        st_ff.nmi_cfg[wku_pkg::NCF_RISE] || st_ff.nmi_cfg[wku_pkg::NCF_FALL] |-> nmi_mux_lock[0])
        else $error("enabled nmi pad not held");

    // pullup ownership
    a_pull_capture: assert property (@(posedge clk) disable iff (rst)
        st_ff.mode == wku_pkg::WKU_RUN && standby_entry && !((reg_wr || reg_rd) && hit_pull)
        |=> pullup_on == $past(st_ff.pull_en[wku_pkg::NUM_EXT-1:0]))
        else $error("pullup not taken at standby");
    a_pull_keep: assert property (@(posedge clk) disable iff (rst)
        !((reg_wr || reg_rd) && hit_pull)
        && !(st_ff.mode == wku_pkg::WKU_RUN && standby_entry) |=> $stable(pullup_on))
        else $error("pullup released early");
    a_pull_drop: assert property (@(posedge clk) disable iff (rst)
        (reg_wr || reg_rd) && hit_pull |=> pullup_on == '0)
        else $error("pullup kept after access");
endmodule : wku_unit
`default_nettype wire

// file: hdl/wku_pkg.sv
/*
 * wku_pkg: shared constants, register offsets and carrier types of the
 * wakeup and interrupt unit.
 * assumes: one system clock; register port with read data one cycle later.
 */
package wku_pkg;
    // geometry
    localparam int NUM_EXT    = 30;
    localparam int NUM_SRC    = 32;  // 30 pads plus 2 on-chip sources
    localparam int NUM_VEC    = 4;
    localparam int NUM_NMI    = 2;
    localparam int ADDR_W     = 8;
    localparam int TIMER_BIT  = 30;  // periodic timer source position
    localparam int ONCHIP_BIT = 31;  // second on-chip source position
    // byte offsets
    localparam logic [7:0] OFS_NMI_FLAGS = 8'h00;
    localparam logic [7:0] OFS_NMI_CFG   = 8'h08;
    localparam logic [7:0] OFS_FLAGS     = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h18;
    localparam logic [7:0] OFS_WAKE_EN   = 8'h1c;
    localparam logic [7:0] OFS_RISE_EN   = 8'h28;
    localparam logic [7:0] OFS_FALL_EN   = 8'h2c;
    localparam logic [7:0] OFS_FILT_EN   = 8'h30;
    localparam logic [7:0] OFS_PULL_EN   = 8'h34;
    // nmi field layout within one byte per input
    localparam int NMI_CFG_W  = 8;
    localparam int NCF_LOCK   = 7;
    localparam int NCF_DST_HI = 6;
    localparam int NCF_DST_LO = 5;
    localparam int NCF_WAKE   = 3;
    localparam int NCF_RISE   = 2;
    localparam int NCF_FALL   = 1;
    localparam int NCF_FILT   = 0;
    localparam int NFL_EVENT  = 0;   // flag byte bit positions per input
    localparam int NFL_OVR    = 1;
    localparam logic [1:0] DST_NMI  = 2'h0;
    localparam logic [1:0] DST_CRIT = 2'h1;
    localparam logic [1:0] DST_MCHK = 2'h2;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // nmi request outputs, one bit per input
    typedef struct packed {
        logic [NUM_NMI-1:0] nmi;
        logic [NUM_NMI-1:0] crit;
        logic [NUM_NMI-1:0] mchk;
    } wku_nmi_req_t;

    typedef enum logic [1:0] {
        WKU_RUN  = 2'b01,
        WKU_STBY = 2'b10
    } wku_mode_t;
endpackage : wku_pkg

// file: testbench/wku_far_model.sv
/*
 * wku_far_model: behavioural mode-entry side that consumes the wakeup request.
 * assumes: driven on the system clock; enters standby on a one-cycle command
 * and leaves it as soon as the combined wakeup request is seen high.
 */
`timescale 1ns/1ps
`default_nettype none
module wku_far_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // control from the bench and request from the unit
    input  wire logic stby_cmd,
    input  wire logic wakeup_req,
    // mode seen by the unit
    output logic      standby_entry
);
    // standby level: set on command, dropped by the unit's wakeup
    always_ff @(posedge clk) begin
        if (rst) begin
            standby_entry <= 1'b0;
        end else if (standby_entry && wakeup_req) begin
            standby_entry <= 1'b0;
        end else if (stby_cmd) begin
            standby_entry <= 1'b1;
        end
    end
endmodule : wku_far_model
`default_nettype wire

// file: testbench/tb_top.sv
/*
 * tb_top: self-checking bench for wku_unit with a mode-entry model.
 * assumes: 40 MHz clock, synchronous active-high reset held 6 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value at %0t: got %h exp %h", $time, (got), (exp)); end end
module tb_top;
    logic                  clk;
    logic                  rst;
    logic [7:0]            reg_addr;
    logic [31:0]           reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [31:0]           reg_rdata;
    logic [29:0]           pad_in;
    logic                  timer_wake_in;
    logic                  onchip_wake_in;
    logic [1:0]            nmi_pad_in;
    logic                  standby_entry;
    logic                  stby_cmd;
    logic [3:0]            irq_vec;
    logic                  wakeup_req;
    wku_pkg::wku_nmi_req_t nmi_req;
    logic [29:0]           filter_en;
    logic [29:0]           pullup_on;
    logic [1:0]            nmi_filter_en;
    logic [1:0]            nmi_mux_lock;
    int                    fails;
    int                    n_tests;

    wku_unit u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
        .timer_wake_in(timer_wake_in), .onchip_wake_in(onchip_wake_in),
        .nmi_pad_in(nmi_pad_in), .standby_entry(standby_entry), .irq_vec(irq_vec),
        .wakeup_req(wakeup_req), .nmi_req(nmi_req), .filter_en(filter_en),
        .pullup_on(pullup_on), .nmi_filter_en(nmi_filter_en), .nmi_mux_lock(nmi_mux_lock));
    wku_far_model u_far (.clk(clk), .rst(rst), .stby_cmd(stby_cmd),
        .wakeup_req(wakeup_req), .standby_entry(standby_entry));

    // clock generator
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // settle n edges, then sample after updates have landed
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // one-cycle read, data compared in the following cycle
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : rd_chk

    // move one pad and wait past synchroniser and flag update
    task automatic pad(input int i, input logic v);
        @(posedge clk);
        pad_in[i] <= v;
        step(6);
    endtask : pad

    task automatic nmi_pad(input int i, input logic v);
        @(posedge clk);
        nmi_pad_in[i] <= v;
        step(6);
    endtask : nmi_pad

    // reset values, disabled nmi edges and an unmapped slot
    task automatic t_reset;
        rd_chk(wku_pkg::OFS_NMI_CFG, 32'h0);
        nmi_pad(1, 1'b1);
        nmi_pad(1, 1'b0);
        rd_chk(wku_pkg::OFS_NMI_FLAGS, 32'h0);
        `CHK(nmi_req, 6'h0)
        wr(8'h04, 32'hffff_ffff);
        rd_chk(8'h04, 32'h0);
        rd_chk(wku_pkg::OFS_PULL_EN, 32'h0);
        wr(wku_pkg::OFS_FILT_EN, 32'hffff_ffff);
        step(2);
        `CHK(filter_en, 30'h3fff_ffff)
        $display("test reset done");
    endtask : t_reset

    // edge selection, clear-by-one, grouping and request gating
    task automatic t_edges;
        wr(wku_pkg::OFS_RISE_EN, 32'h4000_0201); // timer source on rise only
        wr(wku_pkg::OFS_FALL_EN, 32'h0002_0200);
        wr(wku_pkg::OFS_IRQ_EN, 32'hffff_ffff);
        pad(0, 1'b1);
        pad(9, 1'b1);
        pad(17, 1'b1);
        pad(25, 1'b1);
        pad(25, 1'b0);
        rd_chk(wku_pkg::OFS_FLAGS, 32'h0000_0201);
        wr(wku_pkg::OFS_FLAGS, 32'h0000_0200);
        pad(9, 1'b0);
        pad(17, 1'b0);
        @(posedge clk);
        timer_wake_in <= 1'b1;
        step(6);
        rd_chk(wku_pkg::OFS_FLAGS, 32'h4002_0201);
        `CHK(irq_vec, 4'h7)
        `CHK(wakeup_req, 1'b0)
        wr(wku_pkg::OFS_FLAGS, 32'h0);
        rd_chk(wku_pkg::OFS_FLAGS, 32'h4002_0201);
        wr(wku_pkg::OFS_FLAGS, 32'h0000_0001);
        rd_chk(wku_pkg::OFS_FLAGS, 32'h4002_0200);
        wr(wku_pkg::OFS_IRQ_EN, 32'h0000_0200);
        step(2);
        `CHK(irq_vec, 4'h2)
        wr(wku_pkg::OFS_WAKE_EN, 32'h0002_0000);
        step(2);
        `CHK(wakeup_req, 1'b1)
        wr(wku_pkg::OFS_FLAGS, 32'hffff_ffff);
        wr(wku_pkg::OFS_WAKE_EN, 32'h0);
        pad(0, 1'b0);
        `CHK(irq_vec, 4'h0)
        // a clear landing on the same edge as a new event loses to it
        wr(wku_pkg::OFS_RISE_EN, 32'h0000_0020);
        @(posedge clk);
        pad_in[5] <= 1'b1;
        @(posedge clk);
        wr(wku_pkg::OFS_FLAGS, 32'h0000_0020);
        rd_chk(wku_pkg::OFS_FLAGS, 32'h0000_0020);
        wr(wku_pkg::OFS_FLAGS, 32'h0000_0020);
        rd_chk(wku_pkg::OFS_FLAGS, 32'h0);
        $display("test edges done");
    endtask : t_edges

    // every destination code, overrun, wakeup and lock
    task automatic t_nmi;
        for (int d = 0; d < 4; d++) begin
            wr(wku_pkg::OFS_NMI_CFG, {25'h0, d[1:0], 5'h04});
            nmi_pad(0, 1'b1);
            `CHK(nmi_req.nmi, (d == 0) ? 2'b01 : 2'b00)
            `CHK(nmi_req.crit, (d == 1) ? 2'b01 : 2'b00)
            `CHK(nmi_req.mchk, (d == 2) ? 2'b01 : 2'b00)
            nmi_pad(0, 1'b0);
            wr(wku_pkg::OFS_NMI_FLAGS, 32'h3);
        end
        wr(wku_pkg::OFS_NMI_CFG, 32'h0000_432c);
        step(2);
        `CHK(nmi_mux_lock, 2'b11)
        `CHK(nmi_filter_en, 2'b10)
        nmi_pad(0, 1'b1);
        rd_chk(wku_pkg::OFS_NMI_FLAGS, 32'h1);
        `CHK(wakeup_req, 1'b1)
        nmi_pad(0, 1'b0);
        nmi_pad(0, 1'b1);
        rd_chk(wku_pkg::OFS_NMI_FLAGS, 32'h3);
        wr(wku_pkg::OFS_NMI_FLAGS, 32'h1);
        rd_chk(wku_pkg::OFS_NMI_FLAGS, 32'h2);
        `CHK(nmi_req.crit, 2'b01)
        wr(wku_pkg::OFS_NMI_FLAGS, 32'h2);
        step(2);
        `CHK(nmi_req.crit, 2'b00)
        nmi_pad(1, 1'b1);
        nmi_pad(1, 1'b0);
        `CHK(nmi_req.mchk, 2'b10)
        wr(wku_pkg::OFS_NMI_FLAGS, 32'h0000_0300);
        wr(wku_pkg::OFS_NMI_CFG, 32'h0000_0084);
        wr(wku_pkg::OFS_NMI_CFG, 32'h0);
        rd_chk(wku_pkg::OFS_NMI_CFG, 32'h0000_0084);
        $display("test nmi done");
    endtask : t_nmi

    // pullup capture at standby, on-chip wakeup, release by access
    task automatic t_pullup;
        wr(wku_pkg::OFS_PULL_EN, 32'h0000_0020);
        step(2);
        `CHK(pullup_on, 30'h0)
        wr(wku_pkg::OFS_RISE_EN, 32'h8000_0000);
        wr(wku_pkg::OFS_WAKE_EN, 32'h8000_0000);
        @(posedge clk);
        stby_cmd <= 1'b1;
        @(posedge clk);
        stby_cmd <= 1'b0;
        step(3);
        `CHK(standby_entry, 1'b1)
        `CHK(pullup_on, 30'h20)
        @(posedge clk);
        onchip_wake_in <= 1'b1;
        step(6);
        `CHK(standby_entry, 1'b0)
        `CHK(pullup_on, 30'h20)
        rd_chk(wku_pkg::OFS_FLAGS, 32'h8000_0000);
        rd_chk(wku_pkg::OFS_PULL_EN, 32'h0000_0020);
        step(2);
        `CHK(pullup_on, 30'h0)
        $display("test pullup done");
    endtask : t_pullup

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #(25 * 20000);
        fails++;
        report_and_stop();
    end

    // main sequence
    initial begin
        fails = 0;
        n_tests = 0;
        rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {pad_in, timer_wake_in, onchip_wake_in, nmi_pad_in, stby_cmd} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        step(1);
        `CHK(irq_vec, 4'h0)
        t_reset();
        t_edges();
        t_nmi();
        t_pullup();
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
